// ---- inc/sdi_pkg.sv ----
// Constants and types shared by the split-port burst SRAM interface
package sdi_pkg;

  // ******************************************
  // Widths and array size
  // ******************************************
  localparam int SDI_WORD_W = 18;
  localparam int SDI_LANE_W = 9;
  localparam int SDI_LANES = 2;
  localparam int SDI_ADDR_W = 22;
  // Array held in flip-flops, so only the low address bits index it
  localparam int SDI_IDX_W = 4;
  localparam int SDI_DEPTH = 16;

  // ******************************************
  // Timing
  // ******************************************
  localparam int SDI_CLK_PERIOD_NS = 20;
  localparam int SDI_PLL_LOCK_US = 20;
  localparam int SDI_PLL_LOCK_CYC =
    (SDI_PLL_LOCK_US * 1000 + SDI_CLK_PERIOD_NS - 1) / SDI_CLK_PERIOD_NS;
  localparam int SDI_LOCK_W = 11;
  // Gap without input clock edges that counts as a stopped clock
  localparam int SDI_K_STALL_CYC = 16;
  localparam int SDI_GAP_W = 5;
  // Impedance update period in input clock cycles
  localparam int SDI_CAL_W = 10;
  localparam logic [SDI_CAL_W-1:0] SDI_CAL_LAST = 10'h3ff;
  // Clocks spent before the strap level is trusted
  localparam logic [1:0] SDI_STRAP_SETTLE = 2'h3;

  // ******************************************
  // Types
  // ******************************************
  typedef logic [SDI_WORD_W-1:0] sdi_word_t;
  typedef logic [SDI_LANES-1:0] sdi_lanes_t;
  typedef logic [SDI_ADDR_W-1:0] sdi_addr_t;
  typedef logic [SDI_IDX_W-1:0] sdi_idx_t;

  typedef struct packed {
    sdi_word_t hi;
    sdi_word_t lo;
  } sdi_line_t;

  typedef struct packed {
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic read_select_n;
    logic write_select_n;
    sdi_lanes_t byte_lane_select_n;
    sdi_addr_t addr;
    sdi_word_t wdata;
    logic pll_bypass_n;
  } sdi_pins_in_t;

  typedef struct packed {
    sdi_word_t rdata;
    logic rdata_oe;
    logic echo_strobe;
    logic echo_strobe_n;
  } sdi_pins_out_t;

  localparam sdi_pins_in_t SDI_PINS_IDLE = '{
    k: 1'h0, k_n: 1'h0, c: 1'h0, c_n: 1'h0,
    read_select_n: 1'h1, write_select_n: 1'h1,
    byte_lane_select_n: 2'h3, addr: 22'h0, wdata: 18'h0,
    pll_bypass_n: 1'h1};

  typedef enum logic [2:0] {
    SDI_RD_IDLE = 3'h1,
    SDI_RD_WORD0 = 3'h2,
    SDI_RD_WORD1 = 3'h4
  } sdi_rd_state_t;

endpackage

// ---- rtl/sdi_core.sv ----
// Split-port double data rate burst SRAM, device side
//
// What this block does
// [R1] Read starts when read select is low at a true input clock rise.
// [R2] Read returns two 18-bit words, lower word first, then upper word.
// [R3] With PLL on, first word at complement edge after next true rise, second one later.
// [R4] Data outputs go high impedance after the next rising output edge.
// [R5] Write starts at true clock rise; first data word captured there.
// [R6] Complement clock rise latches write address and second data word.
// [R7] Both halves captured, the 36 bits commit at the latched address.
// [R8] Deselected write port finishes pending write, then ignores inputs.
// [R9] Two byte lane selects travel with each word; low lanes get written.
// [R10] Lanes with high select keep their stored contents.
// [R11] Both output clocks high at power-on select single clock mode.
// [R12] Read and write ports run independently, same cycle, any address.
// [R13] Reads return newest data, forwarding a write still in flight.
// [R14] Port selects are sampled only on true input clock rises.
// [R15] Deselecting one port leaves the other and pending work intact.
// [R16] Output impedance is recalibrated every 1024 input clock cycles.
// [R17] Two free-running echo strobes follow the output clock phases.
// [R18] With PLL enabled, lock follows 20 us of stable input clock.
// [R19] Controller may stop the input clocks 30 ns or more to reset PLL; here a gap of 16 core clocks is needed.
// [R20] PLL bypass low gives one cycle read latency.
// [R21] Power-up leaves both ports deselected and outputs in high impedance.
// [R22] Both selects high starts nothing; stopped clocks hold all state except the PLL lock.
module sdi_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Memory controller pins
  input wire sdi_pkg::sdi_pins_in_t ctrl_pins,
  // Read port and echo strobes
  output sdi_pkg::sdi_pins_out_t read_port,
  // Status
  output logic pll_locked,
  output logic impedance_update
);
  import sdi_pkg::*;

  // ******************************************
  // Pin synchronisers and edge finding
  // ******************************************
  sdi_pins_in_t meta_q;
  sdi_pins_in_t pins_q;
  logic k_q;
  logic k_n_q;
  logic c_q;
  logic c_n_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= SDI_PINS_IDLE;
      pins_q <= SDI_PINS_IDLE;
    end
    else
    begin
      meta_q <= ctrl_pins;
      pins_q <= meta_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      k_q <= 1'h0;
      k_n_q <= 1'h0;
      c_q <= 1'h0;
      c_n_q <= 1'h0;
    end
    else
    begin
      k_q <= pins_q.k;
      k_n_q <= pins_q.k_n;
      c_q <= pins_q.c;
      c_n_q <= pins_q.c_n;
    end
  end

  logic k_rise;
  logic k_n_rise;
  logic c_rise;
  logic c_n_rise;

  assign k_rise = pins_q.k & ~k_q;
  assign k_n_rise = pins_q.k_n & ~k_n_q;
  assign c_rise = pins_q.c & ~c_q;
  assign c_n_rise = pins_q.c_n & ~c_n_q;

  // ******************************************
  // Single clock strap
  // ******************************************
  // The strap is caught once the synchronisers have filled after reset,
  // and is frozen from then on.
  logic [1:0] strap_cnt_q;
  logic strap_done_q;
  logic single_clk_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'h0;
      single_clk_q <= 1'h0;
    end
    else if (!strap_done_q)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == SDI_STRAP_SETTLE)
      begin
        strap_done_q <= 1'h1;
        single_clk_q <= pins_q.c & pins_q.c_n; // see [R11]
      end
    end
  end

  logic out_rise;
  logic out_n_rise;
  logic pll_on;
  logic first_edge;
  logic second_edge;

  assign out_rise = single_clk_q ? k_rise : c_rise; // see [R11]
  assign out_n_rise = single_clk_q ? k_n_rise : c_n_rise;
  assign pll_on = pins_q.pll_bypass_n;
  // PLL on: C# then C; bypassed: C then C#
  assign first_edge = pll_on ? out_n_rise : out_rise; // see [R3] see [R20]
  assign second_edge = pll_on ? out_rise : out_n_rise;

  // ******************************************
  // Helpers
  // ******************************************
  function automatic sdi_idx_t addr_idx(input sdi_addr_t a);
    addr_idx = a[SDI_IDX_W-1:0];
  endfunction

  // Lane i of the line is taken from fresh only when its select is low
  function automatic sdi_line_t lane_merge(
    input sdi_line_t old,
    input sdi_line_t fresh,
    input sdi_lanes_t sel_hi_n,
    input sdi_lanes_t sel_lo_n
  );
    logic [2*SDI_LANES-1:0] sel_n;
    sdi_line_t r;
    sel_n = {sel_hi_n, sel_lo_n};
    r = old;
    for (int i = 0; i < 2 * SDI_LANES; i++)
    begin
      if (!sel_n[i])
      begin
        r[i*SDI_LANE_W +: SDI_LANE_W] = fresh[i*SDI_LANE_W +: SDI_LANE_W];
      end
    end
    lane_merge = r;
  endfunction

  // ******************************************
  // Write port
  // ******************************************
  sdi_line_t mem_q [SDI_DEPTH];
  logic wr_open_q;
  sdi_word_t wr_lo_q;
  sdi_lanes_t wr_sel_lo_n_q;
  logic commit;
  sdi_idx_t wr_idx;
  sdi_line_t wr_line;

  // Selects are looked at on true clock rises only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_open_q <= 1'h0; // see [R21]
      wr_lo_q <= 18'h0;
      wr_sel_lo_n_q <= 2'h3;
    end
    else if (k_rise)
    begin
      wr_open_q <= ~pins_q.write_select_n; // see [R5] see [R14] see [R22]
      if (!pins_q.write_select_n)
      begin
        wr_lo_q <= pins_q.wdata; // see [R5]
        wr_sel_lo_n_q <= pins_q.byte_lane_select_n; // see [R9]
      end
    end
    else if (commit)
    begin
      // A deselect seen later never cancels this burst
      wr_open_q <= 1'h0; // see [R8] see [R15]
    end
  end

  // Second half, address and commit all on the complement rise
  assign commit = k_n_rise & wr_open_q; // see [R6]
  assign wr_idx = addr_idx(pins_q.addr); // see [R6]
  assign wr_line = '{hi: pins_q.wdata, lo: wr_lo_q};

  always_ff @(posedge clk)
  begin
    if (commit)
    begin
      mem_q[wr_idx] <= lane_merge(mem_q[wr_idx], wr_line,
        pins_q.byte_lane_select_n, wr_sel_lo_n_q); // see [R7] see [R10]
    end
  end

  // ******************************************
  // Read request pipeline
  // ******************************************
  logic rd_pend_q;
  sdi_addr_t rd_addr_q;
  logic arm_q;
  sdi_idx_t arm_idx_q;
  logic launch;
  logic arm_v;
  sdi_idx_t arm_idx;
  logic take;
  sdi_rd_state_t rd_state_q;
  sdi_idx_t burst_idx_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_pend_q <= 1'h0; // see [R21]
      rd_addr_q <= 22'h0;
    end
    else if (k_rise)
    begin
      rd_pend_q <= ~pins_q.read_select_n; // see [R1] see [R14] see [R22]
      if (!pins_q.read_select_n)
      begin
        rd_addr_q <= pins_q.addr; // see [R1]
      end
    end
  end

  // The next true rise hands the request to the output side
  assign launch = k_rise & rd_pend_q; // see [R3] see [R20]
  assign arm_v = launch | arm_q;
  assign arm_idx = launch ? addr_idx(rd_addr_q) : arm_idx_q;
  // A new burst may start while the last word of the previous one stands
  assign take = first_edge & arm_v & (rd_state_q != SDI_RD_WORD0);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      arm_q <= 1'h0;
      arm_idx_q <= 4'h0;
    end
    else
    begin
      arm_q <= arm_v & ~take; // see [R15]
      arm_idx_q <= arm_idx;
    end
  end

  // ******************************************
  // Read burst sequencing
  // ******************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_state_q <= SDI_RD_IDLE;
      burst_idx_q <= 4'h0;
    end
    else
    begin
      unique case (rd_state_q)
        SDI_RD_IDLE:
        begin
          if (take)
          begin
            rd_state_q <= SDI_RD_WORD0;
            burst_idx_q <= arm_idx;
          end
        end
        SDI_RD_WORD0:
        begin
          if (second_edge)
          begin
            rd_state_q <= SDI_RD_WORD1; // see [R2]
          end
        end
        SDI_RD_WORD1:
        begin
          if (take)
          begin
            rd_state_q <= SDI_RD_WORD0;
            burst_idx_q <= arm_idx;
          end
          else if (out_rise)
          begin
            rd_state_q <= SDI_RD_IDLE; // see [R4]
          end
        end
      endcase
    end
  end

  // Array read with forwarding of a commit in the same cycle, so with the PLL on a write
  // launched one true rise after the read select is already seen by the read burst; in bypass only its upper word sees it.
  sdi_idx_t sel_idx;
  sdi_line_t rd_line;

  assign sel_idx = take ? arm_idx : burst_idx_q;
  assign rd_line = (commit && (wr_idx == sel_idx)) ?
    lane_merge(mem_q[sel_idx], wr_line, pins_q.byte_lane_select_n,
      wr_sel_lo_n_q) : mem_q[sel_idx]; // see [R13] see [R12]

  // ******************************************
  // Output registers and echo strobes
  // ******************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      read_port <= '0; // see [R21]
    end
    else
    begin
      read_port.echo_strobe <= single_clk_q ? pins_q.k : pins_q.c; // see [R17]
      read_port.echo_strobe_n <= single_clk_q ? pins_q.k_n : pins_q.c_n;
      if (take)
      begin
        read_port.rdata <= rd_line.lo; // see [R2] see [R3]
        read_port.rdata_oe <= 1'h1;
      end
      else if ((rd_state_q == SDI_RD_WORD0) && second_edge)
      begin
        read_port.rdata <= rd_line.hi; // see [R2]
      end
      else if ((rd_state_q == SDI_RD_WORD1) && out_rise)
      begin
        read_port.rdata_oe <= 1'h0; // see [R4] see [R22]
      end
    end
  end

  // ******************************************
  // Impedance update
  // ******************************************
  logic [SDI_CAL_W-1:0] cal_cnt_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cal_cnt_q <= '0;
      impedance_update <= 1'h0;
    end
    else
    begin
      impedance_update <= 1'h0;
      if (k_rise && strap_done_q)
      begin
        cal_cnt_q <= cal_cnt_q + 10'h1;
        impedance_update <= (cal_cnt_q == SDI_CAL_LAST); // see [R16]
      end
    end
  end

  // ******************************************
  // PLL lock tracking
  // ******************************************
  // Sampling at the core clock cannot see a 30 ns stop, so only a gap of
  // several core cycles without input clock edges restarts the lock.
  logic [SDI_GAP_W-1:0] gap_cnt_q;
  logic stalled;
  logic [SDI_LOCK_W-1:0] lock_cnt_q;

  assign stalled = (gap_cnt_q == SDI_GAP_W'(SDI_K_STALL_CYC));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gap_cnt_q <= '0;
    end
    else if (k_rise || k_n_rise)
    begin
      gap_cnt_q <= '0;
    end
    else if (!stalled)
    begin
      gap_cnt_q <= gap_cnt_q + 5'h1; // see [R19]
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lock_cnt_q <= '0;
      pll_locked <= 1'h0;
    end
    else if (stalled || !pll_on)
    begin
      lock_cnt_q <= '0; // see [R19] see [R20]
      pll_locked <= 1'h0;
    end
    else if (lock_cnt_q == SDI_LOCK_W'(SDI_PLL_LOCK_CYC))
    begin
      pll_locked <= 1'h1; // see [R18]
    end
    else
    begin
      lock_cnt_q <= lock_cnt_q + 11'h1;
    end
  end

endmodule

// ---- test/sdi_core_sva.sv ----
// Port assertions for the split-port burst SRAM interface
module sdi_core_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins
  input wire sdi_pkg::sdi_pins_in_t ctrl_pins,
  input wire sdi_pkg::sdi_pins_out_t read_port,
  // Status
  input wire logic pll_locked,
  input wire logic impedance_update
);
  import sdi_pkg::*;
  // Cycles since read select was last low, saturating
  logic [4:0] since_rd_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge clk)
  begin
    if (rst)
      since_rd_q <= 5'h1f;
    else if (!ctrl_pins.read_select_n)
      since_rd_q <= 5'h0;
    else if (since_rd_q != 5'h1f)
      since_rd_q <= since_rd_q + 5'h1;
  end
  reset_quiet_a:
    assert property (disable iff (1'b0) rst |=> read_port == '0 &&
      !pll_locked && !impedance_update)
    else $error("outputs not quiet after reset");
  cal_pulse_a:
    assert property (impedance_update |=> !impedance_update [*8])
    else $error("impedance update not a lone pulse");
  bypass_lock_a:
    assert property (!ctrl_pins.pll_bypass_n [*8] |-> !pll_locked)
    else $error("lock shown with bypass");
  lock_cause_a:
    assert property ($rose(pll_locked) |->
      ctrl_pins.pll_bypass_n && $past(ctrl_pins.pll_bypass_n, 8))
    else $error("lock without enabled loop");
  rdata_hold_a:
    assert property (!read_port.rdata_oe |=>
      read_port.rdata_oe || $stable(read_port.rdata))
    else $error("read data moved while off");
  burst_len_a:
    assert property ($rose(read_port.rdata_oe) |-> read_port.rdata_oe [*7])
    else $error("burst shorter than two words");
  read_cause_a:
    assert property ($rose(read_port.rdata_oe) |-> since_rd_q <= 5'h14)
    else $error("burst without read select");
  echo_true_a:
    assert property ($rose(ctrl_pins.c) |-> ##[1:6] read_port.echo_strobe)
    else $error("echo strobe missed clock");
  echo_comp_a:
    assert property ($rose(ctrl_pins.c_n) |->
      ##[1:6] read_port.echo_strobe_n)
    else $error("inverted echo strobe missed clock");
endmodule

bind sdi_core sdi_core_chk sdi_core_chk_inst (
  .clk(clk),
  .rst(rst),
  .ctrl_pins(ctrl_pins),
  .read_port(read_port),
  .pll_locked(pll_locked),
  .impedance_update(impedance_update)
);

// ---- test/sdi_core_tb.sv ----
// Self-checking bench for the split-port burst SRAM interface
module sdi_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sdi_pkg::*;
  typedef struct {
    logic r;
    logic w;
    sdi_idx_t ra;
    sdi_idx_t wa;
    sdi_word_t a;
    sdi_word_t b;
    sdi_lanes_t la;
    sdi_lanes_t lb;
    sdi_word_t lo;
    sdi_word_t hi;
  } sdi_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b1;
  logic k;
  logic k_n;
  logic rs_n = 1'b1;
  logic ws_n = 1'b1;
  logic byp = 1'b1;
  sdi_lanes_t bls = 2'h3;
  sdi_addr_t addr = 22'h0;
  sdi_word_t wd = 18'h0;
  sdi_pins_in_t pins;
  sdi_pins_out_t q;
  logic locked;
  logic upd;
  int kr = 0;
  int n;
  int num_errors = 0;
  int compares = 0;
  sdi_row_t rows [6] = '{
    '{1'h1, 1'h0, 4'h0, 4'h3, 18'h12345, 18'h2abcd, 2'h0, 2'h0,
      18'h0, 18'h0},
    '{1'h0, 1'h0, 4'h3, 4'h5, 18'h01111, 18'h3ffff, 2'h0, 2'h0,
      18'h12345, 18'h2abcd},
    '{1'h0, 1'h0, 4'h3, 4'h3, 18'h3c0de, 18'h00077, 2'h1, 2'h3,
      18'h3c145, 18'h2abcd},
    '{1'h0, 1'h1, 4'h5, 4'h3, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0,
      18'h01111, 18'h3ffff},
    '{1'h0, 1'h0, 4'h3, 4'h5, 18'h0, 18'h00abc, 2'h3, 2'h2,
      18'h3c145, 18'h2abcd},
    '{1'h0, 1'h1, 4'h5, 4'h0, 18'h0, 18'h0, 2'h3, 2'h3,
      18'h01111, 18'h3febc}};

  // ******************************************
  // Clocks and instances
  // ******************************************
  // Output clocks follow the input pair, so both are high only while the clocks are stopped
  assign pins = {k, k_n, k, k_n, rs_n, ws_n, bls, addr, wd, byp};
  always #10 clk = ~clk;
  always @(posedge k) kr++;
  sdi_ctrl_model sdi_ctrl_model_inst (.run(run), .k(k), .k_n(k_n));
  sdi_core sdi_core_inst (.clk(clk), .rst(rst), .ctrl_pins(pins),
    .read_port(q), .pll_locked(locked), .impedance_update(upd));

  // ******************************************
  // Tasks
  // ******************************************
  task automatic cmp_w(string s, sdi_word_t got, sdi_word_t exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic cmp_b(string s, logic got, logic exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", s, exp, got);
    end
  endtask
  task automatic done(string s);
    $display("test %s finished", s);
  endtask
  // Synchroniser lag is 2 to 3 clk, so 6 falling edges lands mid-word
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask
  task automatic op(logic r, logic w, sdi_idx_t ra, sdi_idx_t wa,
    sdi_word_t a, sdi_word_t b, sdi_lanes_t la, sdi_lanes_t lb);
    @(posedge k_n);
    repeat (2) @(negedge clk);
    rs_n = r;
    ws_n = w;
    addr = 22'(ra);
    wd = a;
    bls = la;
    @(posedge k);
    repeat (2) @(negedge clk);
    rs_n = 1'b1;
    ws_n = 1'b1;
    addr = 22'(wa);
    wd = b;
    bls = lb;
  endtask
  task automatic rd_chk(sdi_word_t lo, sdi_word_t hi);
    @(posedge k);
    if (byp === 1'b1)
      @(posedge k_n);
    settle();
    cmp_b("oe first", q.rdata_oe, 1'b1);
    cmp_w("low word", q.rdata, lo);
    if (byp === 1'b1)
      @(posedge k);
    else
      @(posedge k_n);
    settle();
    cmp_w("high word", q.rdata, hi);
    @(posedge k);
    settle();
    cmp_b("oe off", q.rdata_oe, 1'b0);
  endtask
  task automatic finish_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ******************************************
  // Sequence
  // ******************************************
  initial
  begin
    repeat (8) @(negedge clk);
    cmp_b("oe in reset", q.rdata_oe, 1'b0);
    rst = 1'b0;
    @(negedge clk);
    cmp_b("lock after reset", locked, 1'b0);
    repeat (1100) @(negedge clk);
    cmp_b("lock", locked, 1'b1);
    done("reset");
    foreach (rows[i])
    begin
      op(rows[i].r, rows[i].w, rows[i].ra, rows[i].wa, rows[i].a,
        rows[i].b, rows[i].la, rows[i].lb);
      if (!rows[i].r)
        rd_chk(rows[i].lo, rows[i].hi);
    end
    done("table");
    op(1'h1, 1'h0, 4'h0, 4'h7, 18'h15555, 18'h2aaaa, 2'h0, 2'h0);
    op(1'h0, 1'h1, 4'h7, 4'h0, 18'h0, 18'h0, 2'h3, 2'h3);
    rd_chk(18'h15555, 18'h2aaaa);
    done("write then read");
    @(posedge upd);
    n = kr;
    @(negedge upd);
    @(posedge upd);
    cmp_w("update spacing", 18'(kr - n), 18'h400);
    done("impedance");
    @(negedge clk);
    byp = 1'b0;
    repeat (10) @(negedge clk);
    cmp_b("lock in bypass", locked, 1'b0);
    op(1'h0, 1'h1, 4'h5, 4'h0, 18'h0, 18'h0, 2'h3, 2'h3);
    rd_chk(18'h01111, 18'h3febc);
    done("bypass");
    byp = 1'b1;
    repeat (1100) @(negedge clk);
    cmp_b("relock", locked, 1'b1);
    run = 1'b0;
    repeat (40) @(negedge clk);
    cmp_b("lock after stop", locked, 1'b0);
    run = 1'b1;
    done("clock stop");
    finish_test();
  end
  initial
  begin
    #1000000;
    num_errors++;
    finish_test();
  end
endmodule

// ---- test/sdi_ctrl_model.sv ----
// Controller-side input clock source for the SRAM bench
module sdi_ctrl_model (
  // Control
  input wire logic run,
  // Input clock pair
  output logic k,
  output logic k_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Free phase against clk; a stop parks both phases high
  initial
  begin
    k = 1'b0;
    k_n = 1'b1;
    #13;
    forever
    begin
      k = 1'b1;
      k_n = !run;
      #80;
      k = !run;
      k_n = 1'b1;
      #80;
    end
  end
endmodule
